// ---- core/sea_pkg.sv ----
// Summary of operation
// RULE1 - Activity bits 0-2: zeroing, settling, ranging
// RULE2 - Activity bits 4-5: measuring, awaiting trigger
// RULE3 - Activity bits 8-9: channel alarms active
// RULE4 - Activity bits 10-11: channel alarms latched
// RULE5 - Condition bits track instrument state live
// RULE6 - All group registers are 16 bits
// RULE7 - Filtered rising edge sets event bit
// RULE8 - Filtered falling edge sets event bit
// RULE9 - Event bits stay set until cleared
// RULE10 - Event read returns contents, then clears
// RULE11 - Summary is OR of mask AND event
// RULE12 - Activity summary drives status byte bit
// RULE13 - Doubt summary drives status byte bit
// RULE14 - Calibration summary feeds doubt condition bit
// RULE15 - Masks and filters write and read back
// RULE16 - Defaults clear activity and doubt masks
// RULE17 - Defaults set calibration and device masks
// RULE18 - Defaults: rise filters ones, fall zeros
// RULE19 - Doubt bit 3: reading may be invalid
// RULE20 - Doubt bit 8: probe needs zeroing
// RULE21 - Calibration bits 2-3: fallback tables used
// RULE22 - Unassigned condition bits zero, never events
// RULE23 - Edge versus previous clock; set beats clear
// RULE24 - Reset equals defaults; events cleared
package sea_pkg;
  localparam int          REG_W       = 16;
  localparam int          GROUPS      = 3;
  localparam int          GRP_ACT     = 0;
  localparam int          GRP_DOUBT   = 1;
  localparam int          GRP_TRIM    = 2;
  localparam int          GRP_STRIDE  = 5;
  // register offsets inside a group
  localparam int          OFS_LEVEL   = 0;
  localparam int          OFS_MASK    = 1;
  localparam int          OFS_LATCH   = 2;
  localparam int          OFS_FALL    = 3;
  localparam int          OFS_RISE    = 4;
  localparam logic [3:0]  IDX_DEV_MASK = 4'hF;
  // activity condition bits
  localparam int          ACT_ZEROING  = 0;
  localparam int          ACT_SETTLING = 1;
  localparam int          ACT_RANGING  = 2;
  localparam int          ACT_MEASURE  = 4;
  localparam int          ACT_TRIGWAIT = 5;
  localparam int          ACT_ALARM1   = 8;
  localparam int          ACT_ALARM2   = 9;
  localparam int          ACT_ALMLAT1  = 10;
  localparam int          ACT_ALMLAT2  = 11;
  // doubt and trim condition bits
  localparam int          DOUBT_VOLT   = 3;
  localparam int          DOUBT_CAL    = 8;
  localparam int          TRIM_FB1     = 2;
  localparam int          TRIM_FB2     = 3;
  // status byte positions
  localparam int          STB_DOUBT    = 3;
  localparam int          STB_ACT      = 7;
  // default and reset values
  localparam logic [15:0] MASK_CLEAR   = 16'h0000;
  localparam logic [15:0] MASK_ALL     = 16'hFFFF;
  localparam logic [15:0] RISE_DEF     = 16'hFFFF;
  localparam logic [15:0] FALL_DEF     = 16'h0000;
  // command opcodes
  localparam logic [1:0]  OP_READ      = 2'h0;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_DEFAULTS  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RESP = 2'h2
  } sea_state_e;
endpackage

// ---- core/sea_group.sv ----
`timescale 1ns/100ps
module sea_group #(
  parameter logic [15:0] MASK_DEF = 16'h0000
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // live condition
  input  wire logic [15:0] cond_i, // RULE6
  // register access
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_mask_i,
  input  wire logic        wr_rise_i,
  input  wire logic        wr_fall_i,
  input  wire logic        rd_clear_i,
  input  wire logic        defaults_i,
  // state
  output logic [15:0]      mask_o,
  output logic [15:0]      rise_o,
  output logic [15:0]      fall_o,
  output logic [15:0]      latch_o,
  output logic             summary_o
);
  logic [15:0] prev_q;
  logic        seen_q;
  logic [15:0] set_w;

  // first cycle after reset only loads history, so a level already high is no edge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      prev_q <= cond_i; // RULE23
      seen_q <= 1'b1;
    end
  end

  assign set_w = {16{seen_q}} & ((cond_i & ~prev_q & rise_o) | // RULE7
                                 (~cond_i & prev_q & fall_o)); // RULE8

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_o <= 16'h0000; // RULE24
    end else begin
      latch_o <= (rd_clear_i ? 16'h0000 : latch_o) | set_w; // RULE9 RULE10 RULE23
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_o <= MASK_DEF; // RULE24
      rise_o <= sea_pkg::RISE_DEF;
      fall_o <= sea_pkg::FALL_DEF;
    end else if (defaults_i) begin
      mask_o <= MASK_DEF; // RULE16 RULE17
      rise_o <= sea_pkg::RISE_DEF; // RULE18
      fall_o <= sea_pkg::FALL_DEF;
    end else begin
      if (wr_mask_i) begin
        mask_o <= wdata_i; // RULE15
      end
      if (wr_rise_i) begin
        rise_o <= wdata_i;
      end
      if (wr_fall_i) begin
        fall_o <= wdata_i;
      end
    end
  end

  assign summary_o = |(latch_o & mask_o); // RULE11
endmodule

// ---- core/sea_status_top.sv ----
`timescale 1ns/100ps
module sea_status_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // instrument state, from logic on the same clock
  input  wire logic        zeroing_i,
  input  wire logic        settling_i,
  input  wire logic        ranging_i,
  input  wire logic        measuring_i,
  input  wire logic        trig_wait_i,
  input  wire logic [1:0]  alarm_i,
  input  wire logic [1:0]  alarm_latched_i,
  input  wire logic        reading_suspect_i,
  input  wire logic        zero_needed_i,
  input  wire logic        chan_one_fallback_table_i,
  input  wire logic        chan_two_fallback_table_i,
  // command port
  input  wire logic        cmd_valid_i,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [3:0]  cmd_reg_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             rsp_err_o,
  // status byte contribution and device mask
  output logic [7:0]       stb_bits_o,
  output logic [15:0]      dev_mask_o
);
  sea_pkg::sea_state_e state_q;
  logic                accept_w;
  logic                is_read_w;
  logic                is_write_w;
  logic                is_def_w;
  logic [15:0]         cond_w    [sea_pkg::GROUPS];
  logic [15:0]         mask_w    [sea_pkg::GROUPS];
  logic [15:0]         rise_w    [sea_pkg::GROUPS];
  logic [15:0]         fall_w    [sea_pkg::GROUPS];
  logic [15:0]         latch_w   [sea_pkg::GROUPS];
  logic [2:0]          summary_w;
  logic [15:0]         rd_data_w;
  logic                rd_ok_w;
  logic                wr_ok_w;

  function automatic logic reg_hit(input logic [3:0] idx, input int grp, input int ofs);
    reg_hit = (idx == 4'(grp * sea_pkg::GRP_STRIDE + ofs));
  endfunction

  assign cmd_ready_o = (state_q == sea_pkg::ST_IDLE);
  assign accept_w    = cmd_valid_i & cmd_ready_o;
  assign is_read_w   = accept_w & (cmd_op_i == sea_pkg::OP_READ);
  assign is_write_w  = accept_w & (cmd_op_i == sea_pkg::OP_WRITE);
  assign is_def_w    = accept_w & (cmd_op_i == sea_pkg::OP_DEFAULTS);

  // condition words are combinational from the inputs; unassigned bits tie low
  always_comb begin
    for (int g = 0; g < sea_pkg::GROUPS; g++) begin
      cond_w[g] = 16'h0000; // RULE22
    end
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_ZEROING]  = zeroing_i; // RULE1 RULE5
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_SETTLING] = settling_i;
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_RANGING]  = ranging_i;
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_MEASURE]  = measuring_i; // RULE2
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_TRIGWAIT] = trig_wait_i;
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_ALARM1]   = alarm_i[0]; // RULE3
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_ALARM2]   = alarm_i[1];
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_ALMLAT1]  = alarm_latched_i[0]; // RULE4
    cond_w[sea_pkg::GRP_ACT][sea_pkg::ACT_ALMLAT2]  = alarm_latched_i[1];
    cond_w[sea_pkg::GRP_DOUBT][sea_pkg::DOUBT_VOLT] = reading_suspect_i; // RULE19
    // the calibration summary shares the calibration bit with the zero request
    cond_w[sea_pkg::GRP_DOUBT][sea_pkg::DOUBT_CAL]  =
      zero_needed_i | summary_w[sea_pkg::GRP_TRIM]; // RULE20 RULE14
    cond_w[sea_pkg::GRP_TRIM][sea_pkg::TRIM_FB1]    = chan_one_fallback_table_i; // RULE21
    cond_w[sea_pkg::GRP_TRIM][sea_pkg::TRIM_FB2]    = chan_two_fallback_table_i;
  end

  for (genvar g = 0; g < sea_pkg::GROUPS; g++) begin : g_grp
    localparam logic [15:0] DEF = (g == sea_pkg::GRP_TRIM) ? sea_pkg::MASK_ALL
                                                           : sea_pkg::MASK_CLEAR;
    sea_group #(
      .MASK_DEF (DEF)
    ) sea_group_inst (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .cond_i     (cond_w[g]),
      .wdata_i    (cmd_wdata_i),
      .wr_mask_i  (is_write_w & reg_hit(cmd_reg_i, g, sea_pkg::OFS_MASK)),
      .wr_rise_i  (is_write_w & reg_hit(cmd_reg_i, g, sea_pkg::OFS_RISE)),
      .wr_fall_i  (is_write_w & reg_hit(cmd_reg_i, g, sea_pkg::OFS_FALL)),
      .rd_clear_i (is_read_w & reg_hit(cmd_reg_i, g, sea_pkg::OFS_LATCH)), // RULE10
      .defaults_i (is_def_w),
      .mask_o     (mask_w[g]),
      .rise_o     (rise_w[g]),
      .fall_o     (fall_w[g]),
      .latch_o    (latch_w[g]),
      .summary_o  (summary_w[g])
    );
  end

  // device group mask lives outside this block but is defaulted here
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_mask_o <= sea_pkg::MASK_ALL; // RULE24
    end else if (is_def_w) begin
      dev_mask_o <= sea_pkg::MASK_ALL; // RULE17
    end else if (is_write_w && cmd_reg_i == sea_pkg::IDX_DEV_MASK) begin
      dev_mask_o <= cmd_wdata_i;
    end
  end

  // read mux; write to a level or latch register is refused
  always_comb begin
    rd_data_w = 16'h0000;
    rd_ok_w   = 1'b0;
    wr_ok_w   = 1'b0;
    if (cmd_reg_i == sea_pkg::IDX_DEV_MASK) begin
      rd_data_w = dev_mask_o;
      rd_ok_w   = 1'b1;
      wr_ok_w   = 1'b1;
    end
    for (int g = 0; g < sea_pkg::GROUPS; g++) begin
      if (reg_hit(cmd_reg_i, g, sea_pkg::OFS_LEVEL)) begin
        rd_data_w = cond_w[g];
        rd_ok_w   = 1'b1;
      end
      if (reg_hit(cmd_reg_i, g, sea_pkg::OFS_MASK)) begin
        rd_data_w = mask_w[g]; // RULE15
        rd_ok_w   = 1'b1;
        wr_ok_w   = 1'b1;
      end
      if (reg_hit(cmd_reg_i, g, sea_pkg::OFS_LATCH)) begin
        rd_data_w = latch_w[g]; // RULE10
        rd_ok_w   = 1'b1;
      end
      if (reg_hit(cmd_reg_i, g, sea_pkg::OFS_FALL)) begin
        rd_data_w = fall_w[g];
        rd_ok_w   = 1'b1;
        wr_ok_w   = 1'b1;
      end
      if (reg_hit(cmd_reg_i, g, sea_pkg::OFS_RISE)) begin
        rd_data_w = rise_w[g];
        rd_ok_w   = 1'b1;
        wr_ok_w   = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sea_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sea_pkg::ST_IDLE: begin
          if (accept_w) begin
            state_q <= sea_pkg::ST_RESP;
          end
        end
        sea_pkg::ST_RESP: begin
          state_q <= sea_pkg::ST_IDLE;
        end
        default: begin
          state_q <= sea_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // response captured at accept, so a read sees the latch before its clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 16'h0000;
      rsp_err_o   <= 1'b0;
    end else begin
      rsp_valid_o <= accept_w;
      if (accept_w) begin
        rsp_data_o <= is_read_w ? rd_data_w : 16'h0000;
        rsp_err_o  <= (is_read_w & ~rd_ok_w) | (is_write_w & ~wr_ok_w) |
                      (cmd_op_i == 2'h3);
      end
    end
  end

  // registered, so the status byte lags the summary by one clock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_bits_o <= 8'h00;
    end else begin
      stb_bits_o                   <= 8'h00;
      stb_bits_o[sea_pkg::STB_ACT]   <= summary_w[sea_pkg::GRP_ACT]; // RULE12
      stb_bits_o[sea_pkg::STB_DOUBT] <= summary_w[sea_pkg::GRP_DOUBT]; // RULE13
    end
  end
endmodule

// ---- tb/sea_status_props.sv ----
`timescale 1ns/100ps
module sea_status_props (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // instrument state
  input wire logic        zeroing_i,
  input wire logic        settling_i,
  input wire logic        ranging_i,
  input wire logic        measuring_i,
  input wire logic        trig_wait_i,
  input wire logic [1:0]  alarm_i,
  input wire logic [1:0]  alarm_latched_i,
  input wire logic        chan_one_fallback_table_i,
  input wire logic        chan_two_fallback_table_i,
  // command port
  input wire logic        cmd_valid_i,
  input wire logic [1:0]  cmd_op_i,
  input wire logic [3:0]  cmd_reg_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic        cmd_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  input wire logic        rsp_err_o,
  // status outputs
  input wire logic [7:0]  stb_bits_o,
  input wire logic [15:0] dev_mask_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = cmd_valid_i && cmd_ready_o;
  AST_RSP_AFTER_TAKE: assert property (take |=> rsp_valid_o ##1 !rsp_valid_o)
    else $error("no single response pulse after a taken request");
  AST_NO_RSP_IDLE: assert property (!take |=> !rsp_valid_o)
    else $error("response without a request");
  AST_READY_IN_RSP: assert property (rsp_valid_o |-> !cmd_ready_o ##1 cmd_ready_o)
    else $error("ready wrong around a response");
  AST_STB_UNUSED: assert property ((stb_bits_o & 8'h77) == 8'h00)
    else $error("status byte bit outside the summary positions");
  // level words are combinational, so the data reflects the take cycle
  AST_ACT_LEVEL: assert property (
    take && cmd_op_i == 2'h0 && cmd_reg_i == 4'h0 |=>
    rsp_data_o == {4'h0, $past(alarm_latched_i), $past(alarm_i), 2'h0, $past(trig_wait_i),
    $past(measuring_i), 1'b0, $past(ranging_i), $past(settling_i), $past(zeroing_i)})
    else $error("activity level word wrong");
  AST_TRIM_LEVEL: assert property (
    take && cmd_op_i == 2'h0 && cmd_reg_i == 4'hA |=>
    rsp_data_o == {12'h000, $past(chan_two_fallback_table_i),
    $past(chan_one_fallback_table_i), 2'h0})
    else $error("calibration level word wrong");
  AST_DEV_WRITE: assert property (
    take && cmd_op_i == 2'h1 && cmd_reg_i == 4'hF |=>
    dev_mask_o == $past(cmd_wdata_i) && !rsp_err_o)
    else $error("device mask write lost");
  AST_DEFAULTS: assert property (take && cmd_op_i == 2'h2 |=> dev_mask_o == 16'hFFFF)
    else $error("defaults left device mask wrong");
  AST_LEVEL_RO: assert property (
    take && cmd_op_i == 2'h1 && cmd_reg_i inside {4'h0, 4'h5, 4'hA}
    |=> rsp_err_o && rsp_data_o == 16'h0000)
    else $error("level write not refused");
endmodule
bind sea_status_top sea_status_props sea_status_props_inst (.*);

// ---- tb/status_event_aggregator_bench.sv ----
`timescale 1ns/100ps
module status_event_aggregator_bench;
  logic        ref_clk_i;
  logic        rst_i;
  logic [12:0] st;
  logic        cmd_valid_i;
  logic [1:0]  cmd_op_i;
  logic [3:0]  cmd_reg_i;
  logic [15:0] cmd_wdata_i;
  logic        cmd_ready_o;
  logic        rsp_valid_o;
  logic [15:0] rsp_data_o;
  logic        rsp_err_o;
  logic [7:0]  stb_bits_o;
  logic [15:0] dev_mask_o;
  logic [15:0] rd;
  logic        re;
  int          mismatches;
  int          n_checks;
  int          cycles;
  logic [3:0]  rw_idx [10] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hB, 4'hD, 4'hE, 4'hF};
  sea_status_top sea_status_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .zeroing_i(st[0]), .settling_i(st[1]),
    .ranging_i(st[2]), .measuring_i(st[3]), .trig_wait_i(st[4]), .alarm_i(st[6:5]),
    .alarm_latched_i(st[8:7]), .reading_suspect_i(st[9]), .zero_needed_i(st[10]),
    .chan_one_fallback_table_i(st[11]), .chan_two_fallback_table_i(st[12]),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_reg_i(cmd_reg_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .stb_bits_o(stb_bits_o),
    .dev_mask_o(dev_mask_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request per call; the leading negedge wait gives the idle cycle so the next take keeps the spacing
  task automatic cmd(input logic [1:0] op, input logic [3:0] r, input logic [15:0] wd);
    @(negedge ref_clk_i);
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready_o});
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_reg_i = r;
    cmd_wdata_i = wd;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    rd = rsp_data_o;
    re = rsp_err_o;
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid_o});
  endtask
  task automatic rdchk(input string what, input logic [3:0] r, input logic [15:0] exp);
    cmd(sea_pkg::OP_READ, r, 16'h0000);
    chk(what, exp, rd);
    chk("read_err", 16'h0000, {15'h0000, re});
  endtask
  task automatic chk_defaults();
    rdchk("act_mask", 4'h1, 16'h0000);
    rdchk("doubt_mask", 4'h6, 16'h0000);
    rdchk("trim_mask", 4'hB, 16'hFFFF);
    chk("dev_mask", 16'hFFFF, dev_mask_o);
    for (int g = 0; g < 3; g++) begin
      rdchk("rise_filter", 4'(g * 5 + 4), 16'hFFFF);
      rdchk("fall_filter", 4'(g * 5 + 3), 16'h0000);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // whole run is under two hundred cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    st = 13'h0000;
    cmd_valid_i = 1'b0;
    cmd_op_i = 2'h0;
    cmd_reg_i = 4'h0;
    cmd_wdata_i = 16'h0000;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk_defaults();
    for (int g = 0; g < 3; g++) rdchk("latch_reset", 4'(g * 5 + 2), 16'h0000);
    foreach (rw_idx[i]) begin
      cmd(sea_pkg::OP_WRITE, rw_idx[i], 16'h5A00 ^ 16'(i));
      chk("write_err", 16'h0000, {15'h0000, re});
    end
    foreach (rw_idx[i]) rdchk("readback", rw_idx[i], 16'h5A00 ^ 16'(i));
    cmd(sea_pkg::OP_WRITE, 4'h1, 16'hFFFF);
    rdchk("full_range", 4'h1, 16'hFFFF);
    cmd(sea_pkg::OP_WRITE, 4'h0, 16'h1234);
    chk("level_write_err", 16'h0001, {15'h0000, re});
    cmd(sea_pkg::OP_WRITE, 4'h7, 16'h1234);
    chk("latch_write_err", 16'h0001, {15'h0000, re});
    cmd(2'h3, 4'h1, 16'h0000);
    chk("illegal_op_err", 16'h0001, {15'h0000, re});
    cmd(sea_pkg::OP_DEFAULTS, 4'h0, 16'h0000);
    chk_defaults();
    st = 13'h1FFF;
    rdchk("act_level", 4'h0, 16'h0F37);
    rdchk("trim_level", 4'hA, 16'h000C);
    rdchk("doubt_level", 4'h5, 16'h0108);
    rdchk("act_latch_rise", 4'h2, 16'h0F37);
    rdchk("act_latch_clear", 4'h2, 16'h0000);
    st = 13'h0000;
    rdchk("act_latch_nofall", 4'h2, 16'h0000);
    cmd(sea_pkg::OP_WRITE, 4'h1, 16'h0001);
    st = 13'h0002;
    repeat (3) @(negedge ref_clk_i);
    chk("stb_masked", 16'h0000, {8'h00, stb_bits_o});
    st = 13'h0003;
    repeat (3) @(negedge ref_clk_i);
    chk("stb_act", 16'h0080, {8'h00, stb_bits_o});
    st = 13'h0000;
    rdchk("act_latch_held", 4'h2, 16'h0003);
    repeat (2) @(negedge ref_clk_i);
    chk("stb_cleared", 16'h0000, {8'h00, stb_bits_o});
    cmd(sea_pkg::OP_WRITE, 4'h6, 16'h0008);
    repeat (2) @(negedge ref_clk_i);
    chk("stb_doubt", 16'h0008, {8'h00, stb_bits_o});
    rdchk("doubt_latch", 4'h7, 16'h0108);
    rdchk("doubt_by_trim", 4'h5, 16'h0100);
    rdchk("trim_latch", 4'hC, 16'h000C);
    rdchk("doubt_trim_gone", 4'h5, 16'h0000);
    cmd(sea_pkg::OP_WRITE, 4'h3, 16'hFFFF);
    st = 13'h0001;
    repeat (2) @(negedge ref_clk_i);
    // empty the latch first so only the falling edge can set it again
    rdchk("act_latch_rise0", 4'h2, 16'h0001);
    st = 13'h0000;
    rdchk("act_latch_fall", 4'h2, 16'h0001);
    // edge and read-clear land on the same clock edge
    fork
      cmd(sea_pkg::OP_READ, 4'h2, 16'h0000);
      begin
        @(negedge ref_clk_i);
        st = 13'h0001;
      end
    join
    chk("latch_before_set", 16'h0000, rd);
    rdchk("set_beats_clear", 4'h2, 16'h0001);
    // second reset in mid-run, with conditions already high at release
    cmd(sea_pkg::OP_WRITE, 4'h1, 16'hFFFF);
    st = 13'h1FFF;
    rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk_defaults();
    for (int g = 0; g < 3; g++) rdchk("latch_mid_reset", 4'(g * 5 + 2), 16'h0000);
    stop_test();
  end
endmodule
